// File: rtl/dsau_defs.svh
`ifndef DSAU_DEFS_SVH
`define DSAU_DEFS_SVH
// ==========================================================
// address map of the data space
`define DSAU_WIN_BIT 15
`define DSAU_Y_BASE 16'h1800
`define DSAU_Y_LAST 16'h1FFF
`define DSAU_RAM_LAST 16'h27FF
// ==========================================================
// pointer steps
`define DSAU_STEP_BYTE 16'h0001
`define DSAU_STEP_WORD 16'h0002
// ==========================================================
// extra cycles of a window read
`define DSAU_EXTRA_NONE 2'h0
`define DSAU_EXTRA_ONE 2'h1
`define DSAU_EXTRA_TWO 2'h2
// ==========================================================
// byte lanes and fill values
`define DSAU_LANE_NONE 2'h0
`define DSAU_LANE_LO 2'h1
`define DSAU_LANE_HI 2'h2
`define DSAU_LANE_BOTH 2'h3
`define DSAU_ZERO16 16'h0000
`define DSAU_ZERO8 8'h00
`define DSAU_PM_TOP 1'h0
`endif

// File: rtl/dsau_pkg.sv
package dsau_pkg;
   // ==========================================================
   // sequencer states
   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_MEM = 4'h2,
      S_DATA = 4'h4,
      S_WAIT = 4'h8
   } dsau_state_t;
   // instruction class of an access
   typedef enum logic [1:0] {
      CLS_MAC_PF = 2'h0,
      CLS_MOVE = 2'h1,
      CLS_DMOVE = 2'h2,
      CLS_OTHER = 2'h3
   } dsau_cls_t;
   // ==========================================================
   // request and control carriers
   typedef struct packed {
      logic valid;
      logic write;
      logic byte_op;
      logic mac;
      dsau_cls_t cls;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dsau_xreq_t;
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } dsau_yreq_t;
   typedef struct packed {
      logic program_window_enable;
      logic [7:0] program_window_page;
      logic table_active;
      logic repeat_active;
      logic repeat_edge;
   } dsau_ctl_t;
   typedef struct packed {
      logic valid;
      logic [15:0] ptr;
      logic byte_op;
      logic mod_en;
      logic [15:0] mod_start;
      logic [15:0] mod_end;
      logic brev_en;
      logic [15:0] brev_mod;
      logic x_write;
   } dsau_agu_req_t;
   // ==========================================================
   // module state
   typedef struct packed {
      logic valid;
      logic [15:0] ptr;
   } dsau_agu_st_t;
   typedef struct packed {
      dsau_state_t state;
      logic [14:0] ram_addr;
      logic ram_re;
      logic [1:0] ram_we;
      logic [15:0] ram_wdata;
      logic [14:0] yram_addr;
      logic yram_re;
      logic [23:0] pm_addr;
      logic pm_re;
      logic write;
      logic win;
      logic byte_op;
      logic hi_byte;
      logic zero_x;
      logic zero_y;
      logic [1:0] wait_cnt;
      logic [15:0] x_rdata;
      logic [15:0] y_rdata;
      logic [15:0] wreg;
      logic done;
      logic addr_err;
   } dsau_regs_t;
endpackage

// File: rtl/dsau_agu.sv
`timescale 1ns/1ns
`include "dsau_defs.svh"
module dsau_agu (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // pointer update request
   input wire dsau_pkg::dsau_agu_req_t req_i,
   // updated pointer
   output logic [15:0] ptr_o,
   output logic valid_o
);
   import dsau_pkg::*;
   dsau_agu_st_t r;
   dsau_agu_st_t next_r;

   // reverse the bit order of a word
   function automatic logic [15:0] bitrev16(input logic [15:0] v);
      logic [15:0] o;
      o = `DSAU_ZERO16;
      for (int i = 0; i < 16; i++) begin
         o[i] = v[15 - i];
      end
      return o;
   endfunction

   // post-increment with scaling, modulo wrap and reverse carry
   always_comb begin
      logic [15:0] inc;
      inc = req_i.ptr + (req_i.byte_op ? `DSAU_STEP_BYTE : `DSAU_STEP_WORD);
      next_r = r;
      next_r.valid = req_i.valid;
      if (req_i.valid) begin
         if (req_i.brev_en && req_i.x_write) begin
            next_r.ptr = bitrev16(bitrev16(req_i.ptr) + bitrev16(req_i.brev_mod));
         end else if (req_i.mod_en && (inc > req_i.mod_end)) begin
            next_r.ptr = req_i.mod_start;
         end else begin
            next_r.ptr = inc;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign ptr_o = r.ptr;
   assign valid_o = r.valid;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // plain post-increment steps by one or two
   ptr_step_a: assert property (
      (req_i.valid && !req_i.mod_en && !req_i.brev_en) |=>
      (valid_o && ptr_o == $past(req_i.ptr) +
       ($past(req_i.byte_op) ? `DSAU_STEP_BYTE : `DSAU_STEP_WORD)))
      else $error("pointer step wrong");
endmodule

// File: rtl/dsau_top.sv
`timescale 1ns/1ns
`include "dsau_defs.svh"
module dsau_top (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // core control
   input wire dsau_pkg::dsau_ctl_t ctl_i,
   // access requests
   input wire dsau_pkg::dsau_xreq_t x_req_i,
   input wire dsau_pkg::dsau_yreq_t y_req_i,
   input wire logic [15:0] wreg_i,
   output logic x_ready_o,
   // access results
   output logic done_o,
   output logic [15:0] x_rdata_o,
   output logic [15:0] y_rdata_o,
   output logic [15:0] wreg_o,
   output logic addr_err_o,
   output logic stall_o,
   // data ram, x side
   output logic [14:0] ram_addr_o,
   output logic ram_re_o,
   output logic [1:0] ram_we_o,
   output logic [15:0] ram_wdata_o,
   input wire logic [15:0] ram_rdata_i,
   // data ram, y read side
   output logic [14:0] yram_addr_o,
   output logic yram_re_o,
   input wire logic [15:0] yram_rdata_i,
   // program memory
   output logic [23:0] pm_addr_o,
   output logic pm_re_o,
   input wire logic [23:0] pm_rdata_i,
   // pointer update
   input wire dsau_pkg::dsau_agu_req_t agu_req_i,
   output logic [15:0] agu_ptr_o,
   output logic agu_valid_o
);
   import dsau_pkg::*;

   // ==========================================================
   // decode helpers
   // address lies inside the y block
   function automatic logic in_y(input logic [15:0] a);
      return (a >= `DSAU_Y_BASE) && (a <= `DSAU_Y_LAST);
   endfunction

   // address is backed by data ram
   function automatic logic impl(input logic [15:0] a);
      return a <= `DSAU_RAM_LAST;
   endfunction

   // byte strobes for a write
   function automatic logic [1:0] lanes(input logic byte_op, input logic a0);
      if (!byte_op) begin
         return `DSAU_LANE_BOTH;
      end else if (a0) begin
         return `DSAU_LANE_HI;
      end else begin
         return `DSAU_LANE_LO;
      end
   endfunction

   // access goes through the program window
   function automatic logic is_win(input dsau_ctl_t c, input logic [15:0] a);
      return c.program_window_enable && !c.table_active && a[`DSAU_WIN_BIT];
   endfunction

   // extra cycles that a window read costs
   function automatic logic [1:0] extra(input dsau_ctl_t c, input dsau_cls_t k);
      if (c.repeat_active) begin
         return c.repeat_edge ? `DSAU_EXTRA_TWO : `DSAU_EXTRA_NONE;
      end else if (k == CLS_OTHER) begin
         return `DSAU_EXTRA_TWO;
      end else begin
         return `DSAU_EXTRA_ONE;
      end
   endfunction

   // ==========================================================
   // state
   dsau_regs_t r;
   dsau_regs_t next_r;
   logic acc;
   logic acc_rd;
   logic win_now;

   // request taken in idle
   assign acc = (r.state == S_IDLE) && x_req_i.valid;
   assign acc_rd = acc && !x_req_i.write;
   assign win_now = is_win(ctl_i, x_req_i.addr);

   // ==========================================================
   // access sequencer
   always_comb begin
      logic misal;
      logic [15:0] word;
      logic [7:0] sel;
      misal = !x_req_i.byte_op && x_req_i.addr[0];
      word = `DSAU_ZERO16;
      sel = `DSAU_ZERO8;
      next_r = r;
      next_r.done = 1'b0;
      next_r.addr_err = 1'b0;
      next_r.ram_re = 1'b0;
      next_r.ram_we = `DSAU_LANE_NONE;
      next_r.yram_re = 1'b0;
      next_r.pm_re = 1'b0;
      case (r.state)
         S_IDLE: begin
            if (x_req_i.valid) begin
               next_r.state = S_MEM;
               next_r.write = x_req_i.write;
               next_r.byte_op = x_req_i.byte_op;
               next_r.hi_byte = x_req_i.addr[0];
               next_r.wreg = wreg_i;
               next_r.addr_err = misal;
               // word decode shared by both byte lanes
               next_r.ram_addr = x_req_i.addr[15:1];
               next_r.pm_addr = {`DSAU_PM_TOP, ctl_i.program_window_page,
                                 x_req_i.addr[14:0]};
               next_r.win = 1'b0;
               next_r.zero_x = 1'b0;
               next_r.zero_y = 1'b1;
               next_r.wait_cnt = `DSAU_EXTRA_NONE;
               if (x_req_i.write) begin
                  // writes take the x path to any address
                  next_r.ram_wdata = x_req_i.byte_op ?
                     {x_req_i.wdata[7:0], x_req_i.wdata[7:0]} : x_req_i.wdata;
                  if (!misal && impl(x_req_i.addr)) begin
                     next_r.ram_we = lanes(x_req_i.byte_op, x_req_i.addr[0]);
                  end
               end else if (win_now) begin
                  next_r.win = 1'b1;
                  next_r.pm_re = 1'b1;
                  next_r.wait_cnt = extra(ctl_i, x_req_i.cls);
               end else begin
                  // linear space unless multiply class splits off y
                  next_r.zero_x = !impl(x_req_i.addr) ||
                     (x_req_i.mac && in_y(x_req_i.addr));
                  next_r.ram_re = !next_r.zero_x;
               end
               if (!x_req_i.write && x_req_i.mac && y_req_i.valid) begin
                  // concurrent word fetch on the y path
                  next_r.zero_y = !in_y(y_req_i.addr);
                  next_r.yram_re = in_y(y_req_i.addr);
                  next_r.yram_addr = y_req_i.addr[15:1];
               end
            end
         end
         S_MEM: begin
            if (r.write) begin
               next_r.done = 1'b1;
               next_r.state = S_IDLE;
            end else begin
               next_r.state = S_DATA;
            end
         end
         S_DATA: begin
            // pick the returned word, zero for a refused address
            if (r.win) begin
               word = pm_rdata_i[15:0];
            end else if (!r.zero_x) begin
               word = ram_rdata_i;
            end
            sel = r.hi_byte ? word[15:8] : word[7:0];
            next_r.x_rdata = r.byte_op ? {`DSAU_ZERO8, sel} : word;
            next_r.y_rdata = r.zero_y ? `DSAU_ZERO16 : yram_rdata_i;
            next_r.wreg = r.byte_op ? {r.wreg[15:8], sel} : word;
            if (r.wait_cnt == `DSAU_EXTRA_NONE) begin
               next_r.done = 1'b1;
               next_r.state = S_IDLE;
            end else begin
               next_r.state = S_WAIT;
            end
         end
         S_WAIT: begin
            // hold the instruction for the second program fetch
            next_r.wait_cnt = r.wait_cnt - `DSAU_EXTRA_ONE;
            if (r.wait_cnt == `DSAU_EXTRA_ONE) begin
               next_r.done = 1'b1;
               next_r.state = S_IDLE;
            end
         end
         default: begin
            next_r.state = S_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.state <= S_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // outputs
   assign x_ready_o = (r.state == S_IDLE);
   assign stall_o = (r.state != S_IDLE);
   assign done_o = r.done;
   assign x_rdata_o = r.x_rdata;
   assign y_rdata_o = r.y_rdata;
   assign wreg_o = r.wreg;
   assign addr_err_o = r.addr_err;
   assign ram_addr_o = r.ram_addr;
   assign ram_re_o = r.ram_re;
   assign ram_we_o = r.ram_we;
   assign ram_wdata_o = r.ram_wdata;
   assign yram_addr_o = r.yram_addr;
   assign yram_re_o = r.yram_re;
   assign pm_addr_o = r.pm_addr;
   assign pm_re_o = r.pm_re;

   // pointer arithmetic
   dsau_agu u_agu (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .req_i(agu_req_i),
      .ptr_o(agu_ptr_o),
      .valid_o(agu_valid_o)
   );

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // window read reaches program memory only
   win_route_a: assert property (acc_rd && win_now |=> pm_re_o && !ram_re_o)
      else $error("window read not routed");

   // window program address built from page and ea
   win_addr_a: assert property (acc_rd && win_now |=>
      pm_addr_o == {`DSAU_PM_TOP, $past(ctl_i.program_window_page), $past(x_req_i.addr[14:0])})
      else $error("window address wrong");

   // window word carries low program bits
   win_data_a: assert property ((r.state == S_DATA) && r.win && !r.byte_op |=>
      x_rdata_o == $past(pm_rdata_i[15:0]))
      else $error("window data wrong");

   // table access keeps the window shut
   table_block_a: assert property (acc_rd && ctl_i.table_active |=> !pm_re_o)
      else $error("window open during table access");

   sequence win_short_s;
      acc_rd && win_now && !ctl_i.repeat_active && (x_req_i.cls != CLS_OTHER);
   endsequence
   sequence win_long_s;
      acc_rd && win_now && (ctl_i.repeat_active ? ctl_i.repeat_edge :
                            (x_req_i.cls == CLS_OTHER));
   endsequence
   sequence win_fast_s;
      acc_rd && win_now && ctl_i.repeat_active && !ctl_i.repeat_edge;
   endsequence

   // one extra cycle for multiply, move and dmove classes outside repeat loops
   extra_one_a: assert property (win_short_s |-> ##1 !done_o [*3] ##1 done_o)
      else $error("move window timing wrong");

   // two extra cycles for other reads and loop edges
   extra_two_a: assert property (win_long_s |-> ##1 !done_o [*4] ##1 done_o)
      else $error("long window timing wrong");

   // inner loop iterations cost nothing extra
   rep_fast_a: assert property (win_fast_s |-> ##1 !done_o [*2] ##1 done_o)
      else $error("repeat window timing wrong");

   // missing memory reads as zero
   unimpl_zero_a: assert property (acc_rd && !win_now && !impl(x_req_i.addr) |->
      ##3 (done_o && x_rdata_o == `DSAU_ZERO16))
      else $error("unimplemented read not zero");

   // y pointer outside y reads zero
   y_zero_a: assert property (acc_rd && x_req_i.mac && y_req_i.valid &&
      !in_y(y_req_i.addr) |-> ##3 (y_rdata_o == `DSAU_ZERO16))
      else $error("foreign y read not zero");

   // byte write strobes only its lane
   byte_lane_a: assert property (acc && x_req_i.write && x_req_i.byte_op &&
      impl(x_req_i.addr) |=>
      ram_we_o == ($past(x_req_i.addr[0]) ? `DSAU_LANE_HI : `DSAU_LANE_LO))
      else $error("byte lane wrong");

   // odd word write traps without writing
   misalign_a: assert property (acc && x_req_i.write && !x_req_i.byte_op &&
      x_req_i.addr[0] |=> addr_err_o && (ram_we_o == `DSAU_LANE_NONE))
      else $error("misaligned write not trapped");

   // byte load leaves high byte intact
   wreg_byte_a: assert property (acc_rd && x_req_i.byte_op |-> ##3
      wreg_o[15:8] == $past(wreg_i[15:8], 3))
      else $error("byte load changed high byte");

   // writes never use the y or program paths
   write_x_only_a: assert property (acc && x_req_i.write |=>
      !yram_re_o && !pm_re_o)
      else $error("write left the x path");

   // byte read puts the selected lane on the low byte
   byte_read_a: assert property (acc_rd && x_req_i.byte_op && !win_now &&
      !x_req_i.mac && impl(x_req_i.addr) |-> ##3
      x_rdata_o == {`DSAU_ZERO8, $past(x_req_i.addr[0], 3) ?
                    $past(ram_rdata_i[15:8]) : $past(ram_rdata_i[7:0])})
      else $error("byte read lane wrong");

   // multiply class fetches both words in one cycle
   mac_both_a: assert property (acc_rd && x_req_i.mac && y_req_i.valid && !win_now &&
      in_y(y_req_i.addr) && impl(x_req_i.addr) && !in_y(x_req_i.addr) |=>
      ram_re_o && yram_re_o)
      else $error("concurrent fetch missing");

   // outside the multiply class the y block is plain x space
   linear_y_a: assert property (acc_rd && !x_req_i.mac && !win_now &&
      in_y(x_req_i.addr) |=> ram_re_o && (ram_addr_o == $past(x_req_i.addr[15:1])))
      else $error("y block not linear");

   // disabled window leaves upper half as plain data space
   win_off_a: assert property (acc_rd && !ctl_i.program_window_enable &&
      x_req_i.addr[`DSAU_WIN_BIT] |=> !pm_re_o && !ram_re_o)
      else $error("window used while disabled");

   // y path hands over whole fetched words
   y_word_a: assert property ((r.state == S_DATA) && !r.zero_y |=>
      y_rdata_o == $past(yram_rdata_i))
      else $error("y word wrong");
endmodule

// File: verification/dsau_mem_model.sv
`timescale 1ns/1ns
module dsau_mem_model (
   // clock
   input wire logic core_clk_i,
   // data ram, x side
   input wire logic [14:0] ram_addr_i,
   input wire logic ram_re_i,
   input wire logic [1:0] ram_we_i,
   input wire logic [15:0] ram_wdata_i,
   output logic [15:0] ram_rdata_o,
   // data ram, y read side
   input wire logic [14:0] yram_addr_i,
   input wire logic yram_re_i,
   output logic [15:0] yram_rdata_o,
   // program memory
   input wire logic [23:0] pm_addr_i,
   input wire logic pm_re_i,
   output logic [23:0] pm_rdata_o
);
   // ==========================================================
   // storage
   logic [15:0] mem [0:16'h13FF];
   // preload a pattern so every word differs from its neighbours
   initial begin
      for (int i = 0; i <= 16'h13FF; i++) begin
         mem[i] = 16'(i * 16'h0107) ^ 16'h5AC3;
      end
      ram_rdata_o = 16'h0000;
      yram_rdata_o = 16'h0000;
      pm_rdata_o = 24'h000000;
   end
   // ==========================================================
   // one cycle read latency; lines toggle when not answering
   always @(posedge core_clk_i) begin
      ram_rdata_o <= (ram_re_i && ram_addr_i <= 15'h13FF) ? mem[ram_addr_i] : ~ram_rdata_o;
      yram_rdata_o <= (yram_re_i && yram_addr_i <= 15'h13FF) ? mem[yram_addr_i] : ~yram_rdata_o;
      // upper byte holds an illegal opcode pattern
      pm_rdata_o <= pm_re_i ? {8'hFF, pm_addr_i[15:0] ^ {pm_addr_i[22:15], 8'h00}} : ~pm_rdata_o;
      if (ram_we_i[0] && ram_addr_i <= 15'h13FF) begin
         mem[ram_addr_i][7:0] <= ram_wdata_i[7:0];
      end
      if (ram_we_i[1] && ram_addr_i <= 15'h13FF) begin
         mem[ram_addr_i][15:8] <= ram_wdata_i[15:8];
      end
   end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
   import dsau_pkg::*;
   typedef struct packed {
      logic rd;
      logic err;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] wr;
      logic [31:0] cyc;
      logic [63:0] t;
   } dsau_exp_t;
   logic core_clk_i, rst_i, x_ready, done, addr_err, stall, agu_valid;
   logic ram_re, yram_re, pm_re, aerr;
   dsau_ctl_t ctl;
   dsau_xreq_t xreq;
   dsau_yreq_t yreq;
   dsau_agu_req_t areq;
   logic [15:0] wreg, x_rdata, y_rdata, wreg_o, agu_ptr, ram_wdata, ram_rdata, yram_rdata;
   logic [14:0] ram_addr, yram_addr;
   logic [1:0] ram_we;
   logic [23:0] pm_addr, pm_rdata;
   logic [15:0] sh [0:16'h13FF];
   logic [31:0] lfsr, r;
   logic [7:0] pg;
   int failures, compares;
   dsau_exp_t xq[$];
   logic [15:0] aq[$];
   dsau_exp_t e;
   // ==========================================================
   // design and memories
   dsau_top i_dsau_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .ctl_i(ctl), .x_req_i(xreq),
      .y_req_i(yreq), .wreg_i(wreg), .x_ready_o(x_ready), .done_o(done), .x_rdata_o(x_rdata),
      .y_rdata_o(y_rdata), .wreg_o(wreg_o), .addr_err_o(addr_err), .stall_o(stall),
      .ram_addr_o(ram_addr), .ram_re_o(ram_re), .ram_we_o(ram_we), .ram_wdata_o(ram_wdata),
      .ram_rdata_i(ram_rdata), .yram_addr_o(yram_addr), .yram_re_o(yram_re),
      .yram_rdata_i(yram_rdata), .pm_addr_o(pm_addr), .pm_re_o(pm_re), .pm_rdata_i(pm_rdata),
      .agu_req_i(areq), .agu_ptr_o(agu_ptr), .agu_valid_o(agu_valid));
   dsau_mem_model i_dsau_mem_model (.core_clk_i(core_clk_i), .ram_addr_i(ram_addr),
      .ram_re_i(ram_re), .ram_we_i(ram_we), .ram_wdata_i(ram_wdata), .ram_rdata_o(ram_rdata),
      .yram_addr_i(yram_addr), .yram_re_i(yram_re), .yram_rdata_o(yram_rdata),
      .pm_addr_i(pm_addr), .pm_re_i(pm_re), .pm_rdata_o(pm_rdata));
   // clock
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] o;
      for (int i = 0; i < 16; i++) o[i] = v[15 - i];
      return o;
   endfunction
   task automatic complete_run();
      if (failures == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one data access; the expected outcome is queued at acceptance
   task automatic access(input logic w, b, mac, input dsau_cls_t c, input logic [15:0] a, wd,
      ya, input logic pwe, tbl, rep, edg);
      dsau_exp_t x;
      logic [15:0] word, wr;
      logic win;
      logic [23:0] pa;
      pg = 8'(rnd());
      wr = 16'(rnd());
      win = pwe && a[15] && !tbl && !w;
      pa = {1'b0, pg, a[14:0]};
      word = (a > 16'h27FF) ? 16'h0000 : sh[a[15:1]];
      if (mac && a >= 16'h1800 && a <= 16'h1FFF) word = 16'h0000;
      if (win) word = pa[15:0] ^ {pa[22:15], 8'h00};
      x.x = b ? {8'h00, a[0] ? word[15:8] : word[7:0]} : word;
      x.wr = b ? {wr[15:8], x.x[7:0]} : word;
      x.y = (mac && ya >= 16'h1800 && ya <= 16'h1FFF) ? sh[ya[15:1]] : 16'h0000;
      x.err = !b && a[0];
      x.cyc = w ? 2 : 3 + (!win ? 0 : rep ? (edg ? 2 : 0) : (c == CLS_OTHER ? 2 : 1));
      x.rd = !w;
      @(posedge core_clk_i);
      ctl <= '{pwe, pg, tbl, rep, edg};
      xreq <= '{1'b1, w, b, mac, c, a, wd};
      yreq <= '{mac, ya};
      wreg <= wr;
      @(posedge core_clk_i);
      while (!x_ready) @(posedge core_clk_i);
      x.t = $time;
      xq.push_back(x);
      xreq.valid <= 1'b0;
      // writes go through the x path only, one lane per byte, none when misaligned
      if (w && a <= 16'h27FF && (b || !a[0])) begin
         if (!b || !a[0]) sh[a[15:1]][7:0] = wd[7:0];
         if (!b || a[0]) sh[a[15:1]][15:8] = wd[15:8];
      end
   endtask
   // pointer update; requests may follow back to back
   task automatic agu(input logic [15:0] p, input logic b, me, input logic [15:0] ms, me_v,
      input logic be, input logic [15:0] bm, input logic xw);
      logic [15:0] n;
      n = p + (b ? 16'h0001 : 16'h0002);
      if (be && xw) n = rev16(rev16(p) + rev16(bm));
      else if (me && n > me_v) n = ms;
      aq.push_back(n);
      @(posedge core_clk_i);
      areq <= '{1'b1, p, b, me, ms, me_v, be, bm, xw};
   endtask
   // ==========================================================
   // result monitor
   always @(posedge core_clk_i) begin
      if (rst_i) aerr = 1'b0;
      else begin
         if (addr_err === 1'b1) aerr = 1'b1;
         if (stall === x_ready) begin
            failures++;
            $display("mismatch at %0t: stall and ready agree", $time);
         end
         if (done === 1'b1) begin
            e = xq.pop_front();
            compares++;
            if (e.rd && (x_rdata !== e.x || y_rdata !== e.y || wreg_o !== e.wr)) begin
               failures++;
               $display("mismatch at %0t: read %h %h %h exp %h %h %h", $time, x_rdata, y_rdata,
                  wreg_o, e.x, e.y, e.wr);
            end
            if (aerr !== e.err || (($time - e.t) / 10) != e.cyc) begin
               failures++;
               $display("mismatch at %0t: trap or cycle count", $time);
            end
            aerr = 1'b0;
         end
         if (agu_valid === 1'b1) begin
            compares++;
            if (agu_ptr !== aq.pop_front()) begin
               failures++;
               $display("mismatch at %0t: pointer %h", $time, agu_ptr);
            end
         end
      end
   end
   // watchdog
   initial begin
      #200000;
      failures++;
      $display("mismatch at %0t: timeout", $time);
      complete_run();
   end
   // ==========================================================
   // stimulus
   initial begin
      rst_i = 1'b1;
      lfsr = 32'h00017AC2;
      ctl = '0;
      xreq = '0;
      yreq = '0;
      wreg = 16'h0000;
      areq = '0;
      failures = 0;
      compares = 0;
      for (int i = 0; i <= 16'h13FF; i++) sh[i] = 16'(i * 16'h0107) ^ 16'h5AC3;
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'b0;
      access(1, 0, 0, CLS_MOVE, 16'h0100, 16'hA55A, 0, 0, 0, 0, 0);
      access(1, 1, 0, CLS_MOVE, 16'h0101, 16'h3C3C, 0, 0, 0, 0, 0);
      access(0, 0, 0, CLS_MOVE, 16'h0100, 0, 0, 0, 0, 0, 0);
      access(0, 1, 0, CLS_MOVE, 16'h0100, 0, 0, 0, 0, 0, 0);
      access(0, 1, 0, CLS_MOVE, 16'h0101, 0, 0, 0, 0, 0, 0);
      access(1, 0, 0, CLS_MOVE, 16'h0103, 16'hFFFF, 0, 0, 0, 0, 0);
      access(0, 0, 0, CLS_MOVE, 16'h0102, 0, 0, 0, 0, 0, 0);
      access(0, 0, 0, CLS_MOVE, 16'h0103, 0, 0, 0, 0, 0, 0);
      access(0, 0, 0, CLS_MOVE, 16'h3000, 0, 0, 0, 0, 0, 0);
      access(0, 0, 0, CLS_MOVE, 16'h8000, 0, 0, 0, 0, 0, 0);
      for (int c = 0; c < 4; c++) access(0, 0, 0, dsau_cls_t'(c), 16'hC246, 0, 0, 1, 0, 0, 0);
      for (int i = 0; i < 4; i++) access(0, i[1], 0, CLS_OTHER, 16'h8A13, 0, 0, 1, 0, 1, i[0]);
      access(0, 0, 0, CLS_MOVE, 16'h8004, 0, 0, 1, 1, 0, 0);
      access(0, 0, 1, CLS_MAC_PF, 16'h1800, 0, 16'h1802, 0, 0, 0, 0);
      access(0, 0, 1, CLS_MAC_PF, 16'h0200, 0, 16'h0400, 0, 0, 0, 0);
      access(1, 0, 0, CLS_OTHER, 16'h1804, 16'h1234, 0, 0, 0, 0, 0);
      access(0, 0, 0, CLS_OTHER, 16'h1804, 0, 0, 0, 0, 0, 0);
      access(0, 0, 1, CLS_MAC_PF, 16'h0202, 0, 16'h1804, 0, 0, 0, 0);
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         access(r[0], r[1], 0, CLS_MOVE, {2'b00, r[29:16]},
            r[1] ? {r[23:16], r[23:16]} : r[31:16], 0, 0, 0, 0, 0);
      end
      agu(16'h0100, 1, 0, 0, 0, 0, 0, 0);
      agu(16'h0100, 0, 0, 0, 0, 0, 0, 0);
      agu(16'h0206, 0, 1, 16'h0200, 16'h0207, 0, 0, 0);
      agu(16'h0204, 0, 1, 16'h0200, 16'h0207, 0, 0, 0);
      agu(16'h0400, 0, 0, 0, 0, 1, 16'h0010, 1);
      agu(16'h0400, 0, 0, 0, 0, 1, 16'h0010, 0);
      @(posedge core_clk_i);
      areq.valid <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      if (xq.size() != 0 || aq.size() != 0) begin
         failures++;
         $display("mismatch at %0t: results missing", $time);
      end
      complete_run();
   end
endmodule
